// ---- hdl/ecp_ctrl_regs.svh ----
// Register offsets, field positions, reset values and mode codes of the capture/compare/PWM unit.
// Included by every design file that decodes the control register or the register bus.
`ifndef ECP_CTRL_REGS_SVH
`define ECP_CTRL_REGS_SVH

`define ECP_ADDR_CTRL     3'h0
`define ECP_ADDR_DUTY     3'h1
`define ECP_ADDR_CAP_LO   3'h2
`define ECP_ADDR_CAP_HI   3'h3
`define ECP_ADDR_STATUS   3'h4
`define ECP_ADDR_MASK     3'h5
`define ECP_ADDR_DEAD     3'h6
`define ECP_ADDR_PINS     3'h7

`define ECP_CTRL_RESET    8'h00
`define ECP_DUTY_RESET    8'h00
`define ECP_DEAD_RESET    8'h00
`define ECP_MASK_RESET    2'h0
`define ECP_STATUS_RESET  2'h0

`define ECP_ST_FLAG       0
`define ECP_ST_SPECIAL    1

`define ECP_M_OFF         4'h0
`define ECP_M_TOGGLE      4'h2
`define ECP_M_CAP_FALL    4'h4
`define ECP_M_CAP_RISE    4'h5
`define ECP_M_CAP_R4      4'h6
`define ECP_M_CAP_R16     4'h7
`define ECP_M_CMP_SET     4'h8
`define ECP_M_CMP_CLR     4'h9
`define ECP_M_CMP_SOFT    4'ha
`define ECP_M_CMP_SPECIAL 4'hb

`define ECP_CFG_SINGLE    2'h0
`define ECP_CFG_FWD       2'h1
`define ECP_CFG_HALF      2'h2
`define ECP_CFG_REV       2'h3

`define ECP_PRE_TOP_4     4'h3
`define ECP_PRE_TOP_16    4'hf

`endif

// ---- hdl/ecp_ctrl_pkg.sv ----
// Types shared by the capture/compare/PWM unit: control layout, pin bundle, operating class.
// Mode codes come from the register header.
`include "ecp_ctrl_regs.svh"

package ecp_ctrl_pkg;

    typedef enum logic [1:0] {
        ECP_OFF  = 2'h0,
        ECP_CAPT = 2'h1,
        ECP_CMP  = 2'h3,
        ECP_PWM  = 2'h2
    } ecp_class_type;

    typedef struct packed {
        logic [1:0] pwm_output_config;
        logic [1:0] duty_low_bits;
        logic [3:0] unit_mode_select;
    } ecp_ctrl_type;

    typedef struct packed {
        logic out_fourth;
        logic out_third;
        logic out_second;
        logic out_primary;
    } ecp_pins_type;

    // Reserved codes fall into the off class so they never drive a pin.
    function automatic ecp_class_type ecp_class(input logic [3:0] mode);
        ecp_class_type c;
        c = ECP_OFF;
        case (mode[3:2])
            2'h0: c = (mode == `ECP_M_TOGGLE) ? ECP_CMP : ECP_OFF;
            2'h1: c = ECP_CAPT;
            2'h2: c = ECP_CMP;
            2'h3: c = ECP_PWM;
            default: c = ECP_OFF;
        endcase
        return c;
    endfunction

endpackage

// ---- hdl/ecp_cap_edge.sv ----
// Capture edge detector with the rising-edge prescaler.
// Assumes the capture input is already synchronous to the clock.
`timescale 1ns/10ps
`include "ecp_ctrl_regs.svh"
module ecp_cap_edge
    import ecp_ctrl_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       cap_in,
    input  wire logic [3:0] mode_in,
    input  wire logic       restart_in,
    output logic            capture_out
);
    logic       prev_q;
    logic [3:0] pre_q;

    wire rise     = cap_in && !prev_q;
    wire fall     = !cap_in && prev_q;
    wire pre_mode = (mode_in == `ECP_M_CAP_R4) || (mode_in == `ECP_M_CAP_R16);
    wire [3:0] pre_top = (mode_in == `ECP_M_CAP_R16) ? `ECP_PRE_TOP_16 : `ECP_PRE_TOP_4;
    wire pre_hit  = pre_mode && rise && (pre_q == pre_top);

    assign capture_out = ((mode_in == `ECP_M_CAP_FALL) && fall)
                       || ((mode_in == `ECP_M_CAP_RISE) && rise)
                       || pre_hit;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_q <= 1'b0;
            pre_q  <= 4'h0;
        end else begin
            prev_q <= cap_in;
            if (restart_in) begin
                pre_q <= 4'h0;
            end else if (pre_mode && rise) begin
                pre_q <= pre_hit ? 4'h0 : pre_q + 4'h1;
            end
        end
    end
endmodule

// ---- hdl/ecp_steer.sv ----
// PWM output steering, polarity and half-bridge dead band.
// Assumes the raw modulated signal comes from the timebase, synchronous to the clock.
`timescale 1ns/10ps
`include "ecp_ctrl_regs.svh"
module ecp_steer
    import ecp_ctrl_pkg::*;
(
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         pwm_in,
    input  wire logic [1:0]   cfg_in,
    input  wire logic [1:0]   pol_in,
    input  wire logic [7:0]   dead_in,
    output ecp_pins_type      level_out,
    output ecp_pins_type      own_out
);
    logic         prev_q;
    logic [7:0]   dead_q;
    ecp_pins_type act;

    // A pwm edge always blanks both half-bridge legs for at least one cycle.
    wire settled = (dead_q == 8'h00) && (pwm_in == prev_q);
    wire leg_a   = pwm_in && settled;
    wire leg_b   = !pwm_in && settled;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_q <= 1'b0;
            dead_q <= 8'h00;
        end else begin
            prev_q <= pwm_in;
            if (pwm_in != prev_q) begin
                dead_q <= dead_in;
            end else if (dead_q != 8'h00) begin
                dead_q <= dead_q - 8'h01;
            end
        end
    end

    always_comb begin
        act     = 4'h0;
        own_out = 4'h0;
        case (cfg_in)
            `ECP_CFG_SINGLE: begin
                act     = {3'h0, pwm_in};
                own_out = 4'h1;
            end
            `ECP_CFG_FWD: begin
                act     = {pwm_in, 2'h0, 1'b1};
                own_out = 4'hf;
            end
            `ECP_CFG_HALF: begin
                act     = {2'h0, leg_b, leg_a};
                own_out = 4'h3;
            end
            default: begin
                act     = {1'b0, 1'b1, pwm_in, 1'b0};
                own_out = 4'hf;
            end
        endcase
    end

    // Bit one of the polarity inverts the primary/third pair, bit zero the second/fourth.
    assign level_out = (act ^ {pol_in[0], pol_in[1], pol_in[0], pol_in[1]}) & own_out;
endmodule

// ---- hdl/ecp_ctrl.sv ----
// Enhanced capture/compare/PWM unit: mode control register, capture, compare and pin steering.
// Assumes a timebase outside supplies the timer value, match pulse and raw PWM signal.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "ecp_ctrl_regs.svh"
module ecp_ctrl
    import ecp_ctrl_pkg::*;
(
    input  wire logic        CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic [2:0]  ADDR_IN,
    input  wire logic [7:0]  WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [7:0]  RDATA_OUT,
    input  wire logic [15:0] TIMER_IN,
    input  wire logic        CAP_IN,
    input  wire logic        MATCH_IN,
    input  wire logic        PWM_IN,
    input  wire logic        ADC_EN_IN,
    output ecp_pins_type     PINS_OUT,
    output ecp_pins_type     PINS_OE_N_OUT,
    output logic      [9:0]  DUTY_OUT,
    output logic             TIMER_RST_OUT,
    output logic             ADC_START_OUT,
    output logic             IRQ_OUT
);
    logic          rst_meta_q;
    logic          rst_n;
    ecp_ctrl_type  ctrl_q;
    logic [7:0]    duty_high_register_q;
    logic [7:0]    dead_q;
    logic [15:0]   cap_q;
    logic [1:0]    status_q;
    logic [1:0]    status_d;
    logic [1:0]    mask_q;
    logic [3:0]    mode_prev_q;
    logic          cmp_pin_q;
    logic          cmp_pin_d;
    ecp_pins_type  steer_lvl;
    ecp_pins_type  steer_own;
    ecp_pins_type  pins_d;
    ecp_pins_type  oe_n_d;
    logic          cap_hit;

    // The reset is released through two flops so every register leaves reset on one edge.
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    wire [3:0]     mode     = ctrl_q.unit_mode_select;
    wire [1:0]     cfg      = ctrl_q.pwm_output_config;
    ecp_class_type cls;
    assign cls = ecp_class(mode);

    wire wr_ctrl   = WR_IN && (ADDR_IN == `ECP_ADDR_CTRL);
    wire wr_duty   = WR_IN && (ADDR_IN == `ECP_ADDR_DUTY);
    wire wr_status = WR_IN && (ADDR_IN == `ECP_ADDR_STATUS);
    wire wr_mask   = WR_IN && (ADDR_IN == `ECP_ADDR_MASK);
    wire wr_dead   = WR_IN && (ADDR_IN == `ECP_ADDR_DEAD);

    // A mode change is an entry; set and clear modes initialise the pin, toggle holds it, and matches are ignored that cycle.
    wire entering  = mode != mode_prev_q;
    wire mode_off  = mode == `ECP_M_OFF;
    wire cmp_hit   = (cls == ECP_CMP) && MATCH_IN && !entering;
    wire special   = cmp_hit && (mode == `ECP_M_CMP_SPECIAL);
    wire cmp_drive = (cls == ECP_CMP) && (mode != `ECP_M_CMP_SOFT)
                     && (mode != `ECP_M_CMP_SPECIAL);

    ecp_cap_edge u_cap_edge (
        .clk_in      (CLK_IN),
        .rst_n_in    (rst_n),
        .cap_in      (CAP_IN),
        .mode_in     (mode),
        .restart_in  (entering || mode_off),
        .capture_out (cap_hit)
    );

    ecp_steer u_steer (
        .clk_in    (CLK_IN),
        .rst_n_in  (rst_n),
        .pwm_in    (PWM_IN),
        .cfg_in    (cfg),
        .pol_in    (mode[1:0]),
        .dead_in   (dead_q),
        .level_out (steer_lvl),
        .own_out   (steer_own)
    );

    always_comb begin
        cmp_pin_d = cmp_pin_q;
        case (mode)
            `ECP_M_OFF: cmp_pin_d = 1'b0;
            `ECP_M_TOGGLE: begin
                if (cmp_hit) begin
                    cmp_pin_d = !cmp_pin_q;
                end
            end
            `ECP_M_CMP_SET: begin
                if (entering) begin
                    cmp_pin_d = 1'b0;
                end else if (cmp_hit) begin
                    cmp_pin_d = 1'b1;
                end
            end
            `ECP_M_CMP_CLR: begin
                if (entering) begin
                    cmp_pin_d = 1'b1;
                end else if (cmp_hit) begin
                    cmp_pin_d = 1'b0;
                end
            end
            default: cmp_pin_d = cmp_pin_q;
        endcase
    end

    // Config is only looked at in PWM; other classes drive at most the primary pin.
    assign pins_d = (cls == ECP_PWM) ? steer_lvl : {3'h0, cmp_drive && cmp_pin_d};
    assign oe_n_d = (cls == ECP_PWM) ? ~steer_own : {3'h7, !cmp_drive};

    // A hardware event in the same cycle as a write-one clear wins over the clear.
    wire [1:0] st_set = {special, cmp_hit || cap_hit};
    wire [1:0] st_clr = wr_status ? WDATA_IN[1:0] : 2'h0;
    assign status_d = (status_q & ~st_clr) | st_set;

    wire [7:0] rd_mux =
        (ADDR_IN == `ECP_ADDR_CTRL)   ? ctrl_q :
        (ADDR_IN == `ECP_ADDR_DUTY)   ? duty_high_register_q :
        (ADDR_IN == `ECP_ADDR_CAP_LO) ? cap_q[7:0] :
        (ADDR_IN == `ECP_ADDR_CAP_HI) ? cap_q[15:8] :
        (ADDR_IN == `ECP_ADDR_STATUS) ? {6'h00, status_q} :
        (ADDR_IN == `ECP_ADDR_MASK)   ? {6'h00, mask_q} :
        (ADDR_IN == `ECP_ADDR_DEAD)   ? dead_q :
        {PINS_OE_N_OUT, PINS_OUT};

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q               <= `ECP_CTRL_RESET;
            duty_high_register_q <= `ECP_DUTY_RESET;
            dead_q               <= `ECP_DEAD_RESET;
            mask_q               <= `ECP_MASK_RESET;
            status_q             <= `ECP_STATUS_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= WDATA_IN;
            end
            if (wr_duty) begin
                duty_high_register_q <= WDATA_IN;
            end
            if (wr_dead) begin
                dead_q <= WDATA_IN;
            end
            if (wr_mask) begin
                mask_q <= WDATA_IN[1:0];
            end
            status_q <= status_d;
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            mode_prev_q <= `ECP_M_OFF;
            cmp_pin_q   <= 1'b0;
            cap_q       <= 16'h0000;
        end else begin
            mode_prev_q <= mode;
            cmp_pin_q   <= cmp_pin_d;
            if (cap_hit) begin
                cap_q <= TIMER_IN;
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            RDATA_OUT     <= 8'h00;
            PINS_OUT      <= 4'h0;
            PINS_OE_N_OUT <= 4'hf;
            DUTY_OUT      <= 10'h000;
            TIMER_RST_OUT <= 1'b0;
            ADC_START_OUT <= 1'b0;
            IRQ_OUT       <= 1'b0;
        end else begin
            RDATA_OUT     <= RD_IN ? rd_mux : 8'h00;
            PINS_OUT      <= pins_d;
            PINS_OE_N_OUT <= oe_n_d;
            DUTY_OUT      <= {duty_high_register_q, ctrl_q.duty_low_bits};
            TIMER_RST_OUT <= special;
            ADC_START_OUT <= special && ADC_EN_IN;
            IRQ_OUT       <= |(status_d & mask_q);
        end
    end

    default clocking dflt @(posedge CLK_IN);
    endclocking
    default disable iff (!rst_n);

    wire p_first_low  = mode[1];
    wire p_second_low = mode[0];

    property p_ctrl_write;
        WR_IN && (ADDR_IN == `ECP_ADDR_CTRL) |=> ctrl_q == $past(WDATA_IN);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control register did not take the written value");

    property p_ignore_cfg;
        cls != ECP_PWM |=> PINS_OE_N_OUT[3:1] == 3'h7;
    endproperty
    a_ignore_cfg: assert property (p_ignore_cfg)
        else $error("secondary pins driven outside PWM");

    property p_single;
        cls == ECP_PWM && cfg == `ECP_CFG_SINGLE
        |=> PINS_OE_N_OUT == 4'he
            && PINS_OUT.out_primary == ($past(PWM_IN) ^ $past(p_first_low));
    endproperty
    a_single: assert property (p_single)
        else $error("single output steering wrong");

    property p_fwd;
        cls == ECP_PWM && cfg == `ECP_CFG_FWD
        |=> PINS_OUT.out_primary == !$past(p_first_low)
            && PINS_OUT.out_second == $past(p_second_low)
            && PINS_OUT.out_fourth == ($past(PWM_IN) ^ $past(p_second_low));
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("full-bridge forward steering wrong");

    property p_half;
        cls == ECP_PWM && cfg == `ECP_CFG_HALF
        |=> PINS_OE_N_OUT == 4'hc
            && !((PINS_OUT.out_primary ^ $past(p_first_low))
                 && (PINS_OUT.out_second ^ $past(p_second_low)));
    endproperty
    a_half: assert property (p_half)
        else $error("half-bridge legs active together");

    property p_rev;
        cls == ECP_PWM && cfg == `ECP_CFG_REV
        |=> PINS_OUT.out_third == !$past(p_first_low)
            && PINS_OUT.out_fourth == $past(p_second_low);
    endproperty
    a_rev: assert property (p_rev)
        else $error("full-bridge reverse steering wrong");

    property p_duty;
        1'b1 |=> DUTY_OUT == {$past(duty_high_register_q), $past(ctrl_q.duty_low_bits)};
    endproperty
    a_duty: assert property (p_duty)
        else $error("duty value not assembled");

    property p_off;
        mode_off |=> !cmp_pin_q && PINS_OE_N_OUT == 4'hf;
    endproperty
    a_off: assert property (p_off)
        else $error("off mode left pin state");

    property p_toggle;
        mode == `ECP_M_TOGGLE && !entering && MATCH_IN |=> cmp_pin_q != $past(cmp_pin_q);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle on match missing");

    property p_set_high;
        mode == `ECP_M_CMP_SET && !entering && MATCH_IN
        |=> cmp_pin_q && status_q[`ECP_ST_FLAG] && PINS_OUT.out_primary;
    endproperty
    a_set_high: assert property (p_set_high)
        else $error("compare set-high failed");

    property p_special;
        special |=> TIMER_RST_OUT && ADC_START_OUT == $past(ADC_EN_IN)
                    ##1 TIMER_RST_OUT == $past(special);
    endproperty
    a_special: assert property (p_special)
        else $error("special event trigger wrong");

    property p_capture;
        cap_hit |=> cap_q == $past(TIMER_IN) && status_q[`ECP_ST_FLAG];
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not store timer");

    property p_set_low;
        mode == `ECP_M_CMP_CLR && !entering && MATCH_IN
        |=> !cmp_pin_q && status_q[`ECP_ST_FLAG] && !PINS_OUT.out_primary;
    endproperty
    a_set_low: assert property (p_set_low)
        else $error("compare clear-low failed");

    property p_soft;
        mode == `ECP_M_CMP_SOFT && !entering && MATCH_IN
        |=> status_q[`ECP_ST_FLAG] && PINS_OE_N_OUT.out_primary;
    endproperty
    a_soft: assert property (p_soft)
        else $error("software compare drove the pin or missed the flag");

    property p_cap_rise;
        mode == `ECP_M_CAP_RISE && $rose(CAP_IN) |-> cap_hit;
    endproperty
    a_cap_rise: assert property (p_cap_rise)
        else $error("rising edge not captured");

    property p_cap_fall;
        mode == `ECP_M_CAP_FALL && $fell(CAP_IN) |-> cap_hit;
    endproperty
    a_cap_fall: assert property (p_cap_fall)
        else $error("falling edge not captured");

    // The mask is taken from the previous cycle because a mask write lands with the output.
    property p_irq;
        1'b1 |=> IRQ_OUT == |(status_q & $past(mask_q));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt line disagrees with masked status");

    c_capture: cover property (cap_hit && mode == `ECP_M_CAP_R16);
    c_half:    cover property (cls == ECP_PWM && cfg == `ECP_CFG_HALF && $rose(PWM_IN));
    c_special: cover property (special && ADC_EN_IN);
    c_irq:     cover property ($rose(IRQ_OUT));
endmodule

// ---- verification/ecp_pin_model.sv ----
// Far-side model of the unit's pins: drives the capture input, resolves the four pin lines.
// Assumes one clock shared with the unit; a line that nobody drives falls to its pull-down.
`timescale 1ns/10ps
module ecp_pin_model
    import ecp_ctrl_pkg::*;
(
    input  wire logic         clk_in,
    input  wire ecp_pins_type level_in,
    input  wire ecp_pins_type drive_n_in,
    output logic              cap_out,
    output logic [3:0]        line_out
);
    // Released lines show the pull-down, so a stale level can never pass for a driven one.
    assign line_out = level_in & ~drive_n_in;

    initial cap_out = 1'h0;

    // One capture pulse: a rising edge, two cycles high, a falling edge, two cycles low.
    task automatic pulse();
        @(posedge clk_in);
        cap_out <= 1'h1;
        repeat (2) @(posedge clk_in);
        cap_out <= 1'h0;
        repeat (2) @(posedge clk_in);
    endtask
endmodule

// ---- verification/ecp_ctrl_tb.sv ----
// Self-checking bench of the capture/compare/PWM unit: registers, capture, compare, steering.
// Assumes the pin model stands on the far side; the bench plays timebase and software.
`timescale 1ns/10ps
`include "ecp_ctrl_regs.svh"
`define CHK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module ecp_ctrl_tb
    import ecp_ctrl_pkg::*;
;
    localparam int LIMIT = 10000;
    logic         clk;
    logic         rst_n;
    logic [2:0]   addr;
    logic [7:0]   wdata;
    logic         wr;
    logic         rd;
    logic [7:0]   rdata;
    logic [15:0]  timer;
    logic         cap;
    logic         match_p;
    logic         pwm;
    logic         adc_en;
    ecp_pins_type pins;
    ecp_pins_type pins_oe_n;
    logic [9:0]   duty;
    logic         tmr_rst;
    logic         adc_start;
    logic         irq;
    logic [3:0]   line;
    int           fails = 0;
    int           n_compared = 0;
    int           cycles_run = 0;
    int           n_trst = 0;
    int           n_adc = 0;
    // Rows: address, write data, expected read back.
    logic [18:0]  reg_rows [8] = '{{3'h0, 8'hf0, 8'hf0}, {3'h0, 8'h0f, 8'h0f},
        {3'h1, 8'ha5, 8'ha5}, {3'h5, 8'h03, 8'h03}, {3'h6, 8'h07, 8'h07},
        {3'h2, 8'hff, 8'h00}, {3'h3, 8'hff, 8'h00}, {3'h4, 8'hff, 8'h00}};
    // Rows: mode, {oe_n, level} of primary before and after a match, expected status.
    logic [15:0]  cmp_rows [8] = '{{4'h8, 2'h0, 2'h1, 8'h01}, {4'h9, 2'h1, 2'h0, 8'h01},
        {4'h2, 2'h0, 2'h1, 8'h01}, {4'ha, 2'h2, 2'h2, 8'h01}, {4'hb, 2'h2, 2'h2, 8'h03},
        {4'h0, 2'h2, 2'h2, 8'h00}, {4'h1, 2'h2, 2'h2, 8'h00}, {4'h3, 2'h2, 2'h2, 8'h00}};

    ecp_ctrl uut (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .TIMER_IN(timer), .CAP_IN(cap),
        .MATCH_IN(match_p), .PWM_IN(pwm), .ADC_EN_IN(adc_en), .PINS_OUT(pins),
        .PINS_OE_N_OUT(pins_oe_n), .DUTY_OUT(duty), .TIMER_RST_OUT(tmr_rst),
        .ADC_START_OUT(adc_start), .IRQ_OUT(irq));

    ecp_pin_model pm (.clk_in(clk), .level_in(pins), .drive_n_in(pins_oe_n),
        .cap_out(cap), .line_out(line));

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    task automatic finish_test();
        if (fails == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles_run++;
        n_trst += int'(tmr_rst === 1'h1);
        n_adc += int'(adc_start === 1'h1);
        if (cycles_run == LIMIT) begin
            fails++;
            finish_test();
        end
    end

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask

    task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        `CHK(rdata, e)
    endtask

    task automatic pulse_match();
        @(posedge clk);
        match_p <= 1'h1;
        @(posedge clk);
        match_p <= 1'h0;
        cycles(2);
        #1;
    endtask

    task automatic cap_case(input logic [3:0] mode, input int n);
        wr_reg(3'h0, {4'h0, mode});
        cycles(3);
        for (int i = 1; i <= n; i++) begin
            @(posedge clk);
            timer <= {8'h12, 8'(i)};
            pm.pulse();
            chk_reg(3'h4, (i == n) ? 8'h01 : 8'h00);
            `CHK(irq, (i == n))
        end
        chk_reg(3'h2, 8'(n));
        chk_reg(3'h3, 8'h12);
        wr_reg(3'h4, 8'h01);
        cycles(1);
        #1;
        `CHK(irq, 1'h0)
    endtask

    // Pin view {oe_n, level} for one steering setting, polarity and raw level.
    function automatic logic [7:0] exp_pins(input logic [1:0] c, input logic [1:0] p,
                                            input logic m);
        logic [3:0] own;
        logic [3:0] act;
        own = (c == 2'h0) ? 4'h1 : (c == 2'h2) ? 4'h3 : 4'hf;
        act = (c == 2'h0) ? {3'h0, m} : (c == 2'h1) ? {m, 3'h1} :
              (c == 2'h2) ? {2'h0, ~m, m} : {2'h1, m, 1'h0};
        return {~own, (act ^ {p[0], p[1], p[0], p[1]}) & own};
    endfunction

    initial begin
        {rst_n, wr, rd, match_p, pwm} = 5'h00;
        adc_en = 1'h1;
        addr = 3'h0;
        wdata = 8'h00;
        timer = 16'h0000;
        repeat (4) @(posedge clk);
        #1;
        `CHK({pins_oe_n, pins, rdata, irq}, {4'hf, 4'h0, 8'h00, 1'h0})
        @(posedge clk);
        rst_n <= 1'h1;
        cycles(3);
        foreach (reg_rows[i]) begin
            wr_reg(reg_rows[i][18:16], reg_rows[i][15:8]);
            chk_reg(reg_rows[i][18:16], reg_rows[i][7:0]);
        end
        wr_reg(3'h0, 8'h2f);
        cycles(2);
        #1;
        `CHK(duty, 10'h296)
        for (int c = 0; c < 4; c++)
            for (int p = 0; p < 4; p++)
                for (int m = 0; m < 2; m++) begin
                    wr_reg(3'h0, {c[1:0], 2'h0, 2'h3, p[1:0]});
                    pwm <= m[0];
                    cycles(12);
                    #1;
                    `CHK({pins_oe_n, pins}, exp_pins(c[1:0], p[1:0], m[0]))
                end
        wr_reg(3'h0, 8'h8c);
        pwm <= 1'h1;
        cycles(12);
        pwm <= 1'h0;
        cycles(4);
        #1;
        `CHK(pins[1:0], 2'h0)
        cycles(8);
        #1;
        `CHK(pins[1:0], 2'h2)
        wr_reg(3'h0, 8'hc5);
        cycles(3);
        #1;
        `CHK(pins_oe_n, 4'hf)
        cap_case(`ECP_M_CAP_R16, 16);
        cap_case(`ECP_M_CAP_R4, 4);
        cap_case(`ECP_M_CAP_FALL, 1);
        cap_case(`ECP_M_CAP_RISE, 1);
        wr_reg(3'h5, 8'h00);
        pm.pulse();
        chk_reg(3'h4, 8'h01);
        `CHK(irq, 1'h0)
        wr_reg(3'h4, 8'h01);
        wr_reg(3'h5, 8'h03);
        foreach (cmp_rows[i]) begin
            wr_reg(3'h0, {4'h0, cmp_rows[i][15:12]});
            cycles(3);
            #1;
            `CHK({pins_oe_n.out_primary, pins.out_primary}, cmp_rows[i][11:10])
            pulse_match();
            `CHK({pins_oe_n.out_primary, line[0]}, cmp_rows[i][9:8])
            chk_reg(3'h4, cmp_rows[i][7:0]);
            wr_reg(3'h4, 8'h03);
        end
        `CHK({n_trst, n_adc}, {32'd1, 32'd1})
        wr_reg(3'h0, 8'h02);
        cycles(3);
        @(posedge clk);
        match_p <= 1'h1;
        @(posedge clk);
        #1;
        `CHK(pins.out_primary, 1'h1)
        @(posedge clk);
        match_p <= 1'h0;
        #1;
        `CHK(pins.out_primary, 1'h0)
        wr_reg(3'h0, 8'h0b);
        adc_en <= 1'h0;
        cycles(3);
        pulse_match();
        `CHK({n_trst, n_adc}, {32'd2, 32'd1})
        `CHK(irq, 1'h1)
        @(posedge clk);
        rst_n <= 1'h0;
        cycles(2);
        #1;
        `CHK({pins_oe_n, pins, duty, irq}, {4'hf, 4'h0, 10'h000, 1'h0})
        @(posedge clk);
        rst_n <= 1'h1;
        cycles(3);
        chk_reg(3'h0, 8'h00);
        chk_reg(3'h4, 8'h00);
        finish_test();
    end
endmodule
